// File: rtl/sfp_defs.svh
// constants of the serial frame port
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

`define SFP_WORD_BITS       16
`define SFP_CNT_BITS        5
`define SFP_LAST_BIT        5'h0F
`define SFP_FULL_CNT        5'h10
`define SFP_NPINS           8
`define SFP_BUSY_PIN        7
`define SFP_SCLK_WR_MAX_MHZ 50
`define SFP_SCLK_RD_MAX_MHZ 20
`define SFP_CLK_MHZ         10
`define SFP_WORD_RST        16'h0000
`define SFP_PINS_RST        8'h00

`endif

// File: rtl/sfp_pkg.sv
// types of the serial frame port
`include "sfp_defs.svh"
package sfp_pkg;

    typedef enum logic [1:0] {
        SFP_MODE_DAC,
        SFP_MODE_ADC,
        SFP_MODE_DIN,
        SFP_MODE_DOUT
    } sfp_mode_t;

    typedef enum logic [1:0] {
        SFP_PH_IDLE,
        SFP_PH_FRAME,
        SFP_PH_DONE
    } sfp_phase_t;

    typedef struct packed {
        logic                       sclk_s1;
        logic                       sclk_s2;
        logic                       sclk_d;
        logic                       fs_n_s1;
        logic                       fs_n_s2;
        logic                       fs_n_d;
        logic                       sin_s1;
        logic                       sin_s2;
        sfp_phase_t                 phase;
        logic                       armed;
        logic [`SFP_CNT_BITS-1:0]   cnt;
        logic [`SFP_WORD_BITS-1:0]  rx_sh;
        logic [`SFP_WORD_BITS-1:0]  tx_sh;
        logic                       sout;
        logic                       sout_oe;
        logic [`SFP_WORD_BITS-1:0]  rx_word;
        logic                       rx_valid;
        logic [`SFP_NPINS-1:0]      pin_s1;
        logic [`SFP_NPINS-1:0]      pin_s2;
        logic [`SFP_NPINS-1:0]      pin_o;
        logic [`SFP_NPINS-1:0]      pin_oe;
        logic [`SFP_NPINS-1:0]      dac_en;
        logic [`SFP_NPINS-1:0]      adc_en;
        logic [`SFP_NPINS-1:0]      din;
    } sfp_state_t;

endpackage : sfp_pkg

// File: rtl/sfp_port.sv
// serial frame port with configurable pin roles
// What this block does
// R1: each falling serial clock edge in a frame shifts the serial_in bit into the input shift register.
// R2: the host keeps the serial clock at most 50 MHz for writes and 20 MHz for conversions and reads.
// R3: a low reset pin returns everything to defaults at once, and the host holds it high in operation.
// R4: frame select is active low and the 16 falling clock edges after it falls form one frame.
// R5: serial_out changes on rising serial clock edges while the frame is active.
// R6: the most significant output bit is on serial_out as soon as frame select falls.
// R7: the next output bit is given only on the first rising edge after a falling edge in the frame.
// R8: results, read-back and temperature data leave serial_out as a stream, most significant bit first.
// R9: each configurable_pin independently acts as DAC output, ADC input, digital input or digital output.
// R10: when enabled, busy_capable_pin shows a busy level while an ADC conversion runs.
// R11: a frame that ends before 16 falling edges is dropped and changes nothing.
`timescale 1ns/100ps
`default_nettype none
`include "sfp_defs.svh"
module sfp_port
    import sfp_pkg::*;
(
    input  wire logic                       CLK,
    input  wire logic                       ARST_N,
    input  wire logic                       SCLK,
    input  wire logic                       FRAME_SEL_N,
    input  wire logic                       SERIAL_IN,
    output var  logic                       SERIAL_OUT,
    output var  logic                       SERIAL_OUT_OE,
    input  wire logic [`SFP_WORD_BITS-1:0]  TX_WORD,
    output var  logic [`SFP_WORD_BITS-1:0]  RX_WORD,
    output var  logic                       RX_VALID,
    input  wire sfp_mode_t [`SFP_NPINS-1:0] PIN_MODE,
    input  wire logic [`SFP_NPINS-1:0]      DOUT_VAL,
    input  wire logic                       BUSY_EN,
    input  wire logic                       CONV_BUSY,
    input  wire logic [`SFP_NPINS-1:0]      PIN_I,
    output var  logic [`SFP_NPINS-1:0]      PIN_O,
    output var  logic [`SFP_NPINS-1:0]      PIN_OE,
    output var  logic [`SFP_NPINS-1:0]      DAC_EN,
    output var  logic [`SFP_NPINS-1:0]      ADC_EN,
    output var  logic [`SFP_NPINS-1:0]      DIN_VAL
);

    sfp_state_t st_r;
    sfp_state_t st_nxt;
    logic       sclk_fall;
    logic       sclk_rise;
    logic       fs_fall;
    logic       fs_rise;

    // ****************************************
    // edge detection on synchronised pins
    // ****************************************
    assign sclk_fall = st_r.sclk_d & ~st_r.sclk_s2;
    assign sclk_rise = ~st_r.sclk_d & st_r.sclk_s2;
    assign fs_fall   = st_r.fs_n_d & ~st_r.fs_n_s2;
    assign fs_rise   = ~st_r.fs_n_d & st_r.fs_n_s2;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt          = st_r;
        st_nxt.sclk_s1  = SCLK;
        st_nxt.sclk_s2  = st_r.sclk_s1;
        st_nxt.sclk_d   = st_r.sclk_s2;
        st_nxt.fs_n_s1  = FRAME_SEL_N;
        st_nxt.fs_n_s2  = st_r.fs_n_s1;
        st_nxt.fs_n_d   = st_r.fs_n_s2;
        st_nxt.sin_s1   = SERIAL_IN;
        st_nxt.sin_s2   = st_r.sin_s1;
        st_nxt.pin_s1   = PIN_I;
        st_nxt.pin_s2   = st_r.pin_s1;
        st_nxt.rx_valid = 1'b0;
        if (fs_fall) begin
            // new frame: first output bit before any clock edge
            st_nxt.phase   = SFP_PH_FRAME; // R4
            st_nxt.cnt     = '0;
            st_nxt.armed   = 1'b0;
            st_nxt.tx_sh   = TX_WORD;
            st_nxt.sout    = TX_WORD[`SFP_WORD_BITS-1]; // R6
            st_nxt.sout_oe = 1'b1;
        end else if (fs_rise) begin
            // partial word in rx_sh is simply abandoned
            st_nxt.phase   = SFP_PH_IDLE; // R11
            st_nxt.sout_oe = 1'b0;
        end else begin
            unique case (st_r.phase)
                SFP_PH_IDLE: begin
                end
                SFP_PH_FRAME, SFP_PH_DONE: begin
                    if (sclk_fall && st_r.phase == SFP_PH_FRAME) begin
                        st_nxt.rx_sh = {st_r.rx_sh[`SFP_WORD_BITS-2:0], st_r.sin_s2}; // R1
                        st_nxt.cnt   = st_r.cnt + 5'h01;
                        if (st_r.cnt == `SFP_LAST_BIT) begin
                            st_nxt.phase    = SFP_PH_DONE; // R4
                            st_nxt.rx_word  = {st_r.rx_sh[`SFP_WORD_BITS-2:0], st_r.sin_s2};
                            st_nxt.rx_valid = 1'b1;
                        end
                    end
                    if (sclk_fall) begin
                        st_nxt.armed = 1'b1; // R7
                    end else if (sclk_rise && st_r.armed) begin
                        st_nxt.armed = 1'b0; // R7
                        st_nxt.tx_sh = {st_r.tx_sh[`SFP_WORD_BITS-2:0], 1'b0}; // R8
                        st_nxt.sout  = st_r.tx_sh[`SFP_WORD_BITS-2]; // R5
                    end
                end
                default: begin
                    st_nxt.phase = SFP_PH_IDLE;
                end
            endcase
        end
        // pin roles, busy overrides the busy-capable pin
        for (int i = 0; i < `SFP_NPINS; i++) begin
            st_nxt.pin_oe[i] = (PIN_MODE[i] == SFP_MODE_DOUT); // R9
            st_nxt.pin_o[i]  = (PIN_MODE[i] == SFP_MODE_DOUT) & DOUT_VAL[i];
            st_nxt.dac_en[i] = (PIN_MODE[i] == SFP_MODE_DAC);
            st_nxt.adc_en[i] = (PIN_MODE[i] == SFP_MODE_ADC);
            st_nxt.din[i]    = (PIN_MODE[i] == SFP_MODE_DIN) & st_r.pin_s2[i];
        end
        if (BUSY_EN) begin
            st_nxt.pin_oe[`SFP_BUSY_PIN] = 1'b1; // R10
            st_nxt.pin_o[`SFP_BUSY_PIN]  = CONV_BUSY;
            st_nxt.dac_en[`SFP_BUSY_PIN] = 1'b0;
            st_nxt.adc_en[`SFP_BUSY_PIN] = 1'b0;
            st_nxt.din[`SFP_BUSY_PIN]    = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r         <= '0; // R3
            st_r.sclk_s1 <= 1'b0;
            st_r.fs_n_s1 <= 1'b1;
            st_r.fs_n_s2 <= 1'b1;
            st_r.fs_n_d  <= 1'b1;
            st_r.phase   <= SFP_PH_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign SERIAL_OUT    = st_r.sout;
    assign SERIAL_OUT_OE = st_r.sout_oe;
    assign RX_WORD       = st_r.rx_word;
    assign RX_VALID      = st_r.rx_valid;
    assign PIN_O         = st_r.pin_o;
    assign PIN_OE        = st_r.pin_oe;
    assign DAC_EN        = st_r.dac_en;
    assign ADC_EN        = st_r.adc_en;
    assign DIN_VAL       = st_r.din;

    // ****************************************
    // assertions
    // ****************************************
    property p_r1;
        @(posedge CLK) disable iff (!ARST_N)
        (sclk_fall && !fs_fall && !fs_rise && st_r.phase == SFP_PH_FRAME) |=> st_r.rx_sh[0] == $past(st_r.sin_s2);
    endproperty
    a_r1: assert property (p_r1) else $error("input bit not shifted in"); // R1

    property p_r3;
        @(posedge CLK) !ARST_N |-> (!RX_VALID && !SERIAL_OUT_OE && RX_WORD == `SFP_WORD_RST);
    endproperty
    a_r3: assert property (p_r3) else $error("outputs not at defaults in reset"); // R3

    property p_r4;
        @(posedge CLK) disable iff (!ARST_N)
        (sclk_fall && !fs_fall && !fs_rise && st_r.phase == SFP_PH_FRAME && st_r.cnt == `SFP_LAST_BIT)
        |=> RX_VALID && RX_WORD == {$past(st_r.rx_sh[`SFP_WORD_BITS-2:0]), $past(st_r.sin_s2)} ##1 !RX_VALID;
    endproperty
    a_r4: assert property (p_r4) else $error("word not delivered at sixteenth edge"); // R4

    property p_r5;
        @(posedge CLK) disable iff (!ARST_N)
        $changed(SERIAL_OUT) |-> $past(fs_fall) || $past(sclk_rise && st_r.armed);
    endproperty
    a_r5: assert property (p_r5) else $error("serial out changed off a rising edge"); // R5

    property p_r6;
        @(posedge CLK) disable iff (!ARST_N)
        fs_fall |=> SERIAL_OUT == $past(TX_WORD[`SFP_WORD_BITS-1]) && SERIAL_OUT_OE;
    endproperty
    a_r6: assert property (p_r6) else $error("msb not presented at frame start"); // R6

    property p_r7;
        @(posedge CLK) disable iff (!ARST_N)
        (sclk_rise && !st_r.armed && !fs_fall) |=> $stable(SERIAL_OUT) && $stable(st_r.tx_sh);
    endproperty
    a_r7: assert property (p_r7) else $error("output advanced without a prior falling edge"); // R7

    property p_r8;
        @(posedge CLK) disable iff (!ARST_N)
        (sclk_rise && st_r.armed && !fs_fall && !fs_rise && st_r.phase != SFP_PH_IDLE)
        |=> SERIAL_OUT == $past(st_r.tx_sh[`SFP_WORD_BITS-2]);
    endproperty
    a_r8: assert property (p_r8) else $error("output bit order wrong"); // R8

    property p_r9;
        @(posedge CLK) disable iff (!ARST_N)
        (PIN_MODE[0] == SFP_MODE_DOUT) |=> PIN_OE[0] && PIN_O[0] == $past(DOUT_VAL[0]) && !DAC_EN[0] && !ADC_EN[0];
    endproperty
    a_r9: assert property (p_r9) else $error("pin role not applied"); // R9

    property p_r10;
        @(posedge CLK) disable iff (!ARST_N)
        BUSY_EN |=> PIN_OE[`SFP_BUSY_PIN] && PIN_O[`SFP_BUSY_PIN] == $past(CONV_BUSY);
    endproperty
    a_r10: assert property (p_r10) else $error("busy pin not driven"); // R10

    property p_r11;
        @(posedge CLK) disable iff (!ARST_N)
        $changed(RX_WORD) |-> RX_VALID;
    endproperty
    a_r11: assert property (p_r11) else $error("received word changed without a full frame"); // R11

    c_full_frame: cover property (@(posedge CLK) disable iff (!ARST_N) RX_VALID);
    c_short_frame: cover property (@(posedge CLK) disable iff (!ARST_N)
        fs_rise && st_r.phase == SFP_PH_FRAME && st_r.cnt != 5'h00);
    c_busy: cover property (@(posedge CLK) disable iff (!ARST_N) BUSY_EN && CONV_BUSY ##1 PIN_O[`SFP_BUSY_PIN]);

endmodule : sfp_port
`default_nettype wire

// File: verification/sfp_host_model.sv
// host-side serial controller model
`timescale 1ns/100ps
`default_nettype none
module sfp_host_model (
    input  wire logic        start,
    input  wire logic        idle_hi,
    input  wire logic [4:0]  nbits,
    input  wire logic [15:0] tx,
    input  wire logic        sout,
    output var  logic        sclk,
    output var  logic        fs_n,
    output var  logic        serial_in,
    output var  logic [15:0] rx,
    output var  logic        done
);
    initial begin
        sclk = 1'b0;
        fs_n = 1'b1;
        serial_in  = 1'b0;
        rx   = 16'h0000;
        done = 1'b1;
    end
    // clock stands at its idle level outside frames, 800 ns period
    always @(posedge start) begin
        done = 1'b0;
        sclk = idle_hi;
        #37 fs_n = 1'b0;
        #800;
        for (int i = 0; i < 16; i++) begin
            if (i < nbits) begin
                serial_in = tx[15-i];
                #100 sclk = ~idle_hi;
                #300 if (idle_hi) rx[15-i] = sout;
                #100 sclk = idle_hi;
                #300 if (!idle_hi) rx[15-i] = sout;
            end
        end
        #200 fs_n = 1'b1;
        serial_in  = ~serial_in;
        done = 1'b1;
    end
endmodule : sfp_host_model
`default_nettype wire

// File: verification/tb.sv
// self-checking bench of the serial frame port
`timescale 1ns/100ps
`default_nettype none
module tb
    import sfp_pkg::*;
;
    logic        clk, arst_n, sclk, fs_n, serial_in, sout, sout_oe, rx_valid;
    logic        busy_en, conv_busy, start, idle_hi, done;
    logic [15:0] tx_word, rx_word, host_tx, host_rx;
    logic [4:0]  nbits;
    sfp_mode_t [7:0] pin_mode;
    logic [7:0]  dout_val, pin_i, pin_o, pin_oe, dac_en, adc_en, din_val;
    int          error_cnt, total_checks, vcnt, cycles;

    sfp_port sfp_port_inst (.CLK(clk), .ARST_N(arst_n), .SCLK(sclk), .FRAME_SEL_N(fs_n), .SERIAL_IN(serial_in),
        .SERIAL_OUT(sout), .SERIAL_OUT_OE(sout_oe), .TX_WORD(tx_word), .RX_WORD(rx_word),
        .RX_VALID(rx_valid), .PIN_MODE(pin_mode), .DOUT_VAL(dout_val), .BUSY_EN(busy_en),
        .CONV_BUSY(conv_busy), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .DAC_EN(dac_en),
        .ADC_EN(adc_en), .DIN_VAL(din_val));
    sfp_host_model sfp_host_model_inst (.start(start), .idle_hi(idle_hi), .nbits(nbits), .tx(host_tx),
        .sout(sout), .sclk(sclk), .fs_n(fs_n), .serial_in(serial_in), .rx(host_rx), .done(done));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge clk) begin
        cycles++;
        if (rx_valid === 1'b1) vcnt++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("mismatch at %0t: timeout", $time);
            close_out();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task xfer(input logic ih, input logic [4:0] n, input logic [15:0] dout, input logic [15:0] din);
        @(posedge clk);
        #1 idle_hi = ih;
        nbits   = n;
        tx_word = dout;
        host_tx = din;
        vcnt    = 0;
        start   = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        for (int k = 0; k < 400 && done !== 1'b1; k++) @(posedge clk);
        chk({15'h0000, done}, 16'h0001, "frame end");
        repeat (4) @(posedge clk);
        #1;
    endtask : xfer
    task t_frame(input logic ih, input logic [15:0] dout, input logic [15:0] din);
        xfer(ih, 5'h10, dout, din);
        chk(host_rx, dout, "output word");
        chk(rx_word, din, "input word");
        chk(16'(vcnt), 16'h0001, "valid pulses");
        chk({15'h0000, sout_oe}, 16'h0000, "drive after frame");
    endtask : t_frame
    task t_partial();
        logic [15:0] prev;
        prev = rx_word;
        xfer(1'b0, 5'h07, 16'hFFFF, ~prev);
        chk(rx_word, prev, "partial word kept");
        chk(16'(vcnt), 16'h0000, "partial valid");
    endtask : t_partial
    task t_pins();
        logic [7:0] e_dac, e_adc, e_din, e_oe, e_o;
        for (int r = 0; r < 4; r++) begin
            e_dac = 8'h00;
            e_adc = 8'h00;
            e_din = 8'h00;
            e_oe  = 8'h00;
            dout_val = 8'hA5 ^ 8'(r);
            pin_i    = 8'h3C ^ 8'(r);
            for (int i = 0; i < 8; i++) begin
                pin_mode[i] = sfp_mode_t'(2'((i + r) % 4));
                e_dac[i] = (pin_mode[i] == SFP_MODE_DAC);
                e_adc[i] = (pin_mode[i] == SFP_MODE_ADC);
                e_din[i] = (pin_mode[i] == SFP_MODE_DIN) & pin_i[i];
                e_oe[i]  = (pin_mode[i] == SFP_MODE_DOUT);
            end
            e_o = dout_val & e_oe;
            repeat (5) @(posedge clk);
            #1;
            chk({8'h00, dac_en}, {8'h00, e_dac}, "dac roles");
            chk({8'h00, adc_en}, {8'h00, e_adc}, "adc roles");
            chk({8'h00, din_val}, {8'h00, e_din}, "input pins");
            chk({pin_oe, pin_o}, {e_oe, e_o}, "output pins");
        end
    endtask : t_pins
    task t_busy();
        busy_en   = 1'b1;
        conv_busy = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({14'h0000, pin_oe[7], pin_o[7]}, 16'h0003, "busy high");
        conv_busy = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, pin_o[7]}, 16'h0000, "busy low");
        busy_en = 1'b0;
    endtask : t_busy
    task t_reset();
        @(posedge clk);
        #1 arst_n = 1'b0;
        #20 chk(rx_word, 16'h0000, "async reset");
        repeat (3) @(posedge clk);
        #1 arst_n = 1'b1;
    endtask : t_reset
    task close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {arst_n, start, idle_hi, busy_en, conv_busy} = 5'h10;
        {tx_word, host_tx, nbits, dout_val, pin_i} = 53'h0;
        for (int i = 0; i < 8; i++) pin_mode[i] = SFP_MODE_DAC;
        // reset falls after time zero so the state register surely sees the edge
        #1 arst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 arst_n = 1'b1;
        t_frame(1'b0, 16'hC3A5, 16'h8E71);
        t_partial();
        t_frame(1'b1, 16'h5A0F, 16'h0F96);
        t_pins();
        t_busy();
        t_reset();
        t_frame(1'b0, 16'h8001, 16'hFFFE);
        close_out();
    end
endmodule : tb
`default_nettype wire
